// >>> hw/sbc_mode_ctrl.sv
// operating-mode controller: mode sequencing, regulator, reset line, wake
// Function
// - nine modes: normal, standby, pin-query, pre-sleep, sleep, reset, setup, thermal, off
// - regulator on in standby, normal, pin-query, pre-sleep, reset; off in sleep, off
// - filtered output undervoltage pulls reset line low when detection enabled
// - reset leaves for standby when line high and settings valid, pins ignored
// - standby entry waits while someone outside holds the reset line low
// - reset mode holds line low for configured width and until no undervoltage
// - standby: transmitter off, wake inputs watched, wake shown as receive pin low
// - standby to normal: select low setup before strobe rise, held one hold
// - standby to pin-query: select high setup before rise, held; else normal
// - pin-query to normal: select low one hold time while strobe high
// - select back high before hold ends keeps pin-query
// - pin-query to standby: strobe falls with select high held; early low passes normal
// - pin-query shows wake status, setup mode distinguishable, tx/rx same as standby
// - normal to standby: select low setup before strobe fall, held; else toward sleep
// - with sleep inhibit set, strobe fall alone reaches standby from normal
// - normal to pre-sleep: select high setup before strobe fall, held; else standby
// - pre-sleep reports new wake on receive pin; strobe rise goes pin-query
// - pre-sleep enters sleep after strobe low longer than the timeout
// - wake flag during pre-sleep timeout goes reset then standby instead of sleep
// - sleep: regulator and LIN off, reset line low, wake detection running
// - reset line forced low from outside puts device into reset
// - reset width chosen by a settings bit: 0.7 ms or 4.0 ms
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none

module sbc_mode_ctrl #(
    parameter int SETUP_CYC       = sbc_pkg::SETUP_CYC,
    parameter int HOLD_CYC        = sbc_pkg::HOLD_CYC,
    parameter int UV_FILTER_CYC   = sbc_pkg::UV_FILTER_CYC,
    parameter int PRE_SLEEP_CYC   = sbc_pkg::PRE_SLEEP_CYC,
    parameter int RESET_SHORT_CYC = sbc_pkg::RESET_SHORT_CYC,
    parameter int RESET_LONG_CYC  = sbc_pkg::RESET_LONG_CYC
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // pins and analog monitors
    input  wire sbc_pkg::sbc_pins_type pins,
    output var  logic                 regulator_en_q,
    output var  logic                 reset_line_out_q,
    output var  logic                 reset_line_oe_q,
    output var  logic                 rx_out_q,
    output var  logic                 lin_tx_en_q,
    output var  logic                 lin_phy_en_q,
    // register bus
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output var  logic [31:0]          avs_readdata,
    output var  logic                 avs_waitrequest
);

    localparam int W = sbc_pkg::TMR_W;

    if (SETUP_CYC < 1 || HOLD_CYC < 1 || UV_FILTER_CYC < 1 || PRE_SLEEP_CYC < 1 ||
        RESET_SHORT_CYC < 1 || RESET_LONG_CYC < 1 || RESET_LONG_CYC >= 2**W ||
        PRE_SLEEP_CYC >= 2**W || RESET_SHORT_CYC >= 2**W || UV_FILTER_CYC >= 2**W ||
        SETUP_CYC >= 2**W || HOLD_CYC >= 2**W) begin : g_bad_count
        $error("sbc_mode_ctrl: timing count out of range");
    end

    localparam logic [W-1:0] SETUP_N = SETUP_CYC[W-1:0];
    localparam logic [W-1:0] HOLD_N  = HOLD_CYC[W-1:0];
    localparam logic [W-1:0] UV_N    = UV_FILTER_CYC[W-1:0];
    localparam logic [W-1:0] PRE_N   = PRE_SLEEP_CYC[W-1:0];
    localparam logic [W-1:0] RST_S_N = RESET_SHORT_CYC[W-1:0];
    localparam logic [W-1:0] RST_L_N = RESET_LONG_CYC[W-1:0];

    sbc_pkg::sbc_mode_type     mode_q;
    sbc_pkg::sbc_mode_type     last_q;
    sbc_pkg::sbc_settings_type settings_q;
    sbc_pkg::sbc_hold_type     hold_q;
    logic                      strobe_q;
    logic                      sel_q;
    logic                      route_q;
    logic                      wake_q;
    logic [W-1:0]              tmr_q;
    logic [W-1:0]              hold_cnt_q;
    logic [W-1:0]              sel_cnt_q;
    logic [W-1:0]              uv_cnt_q;

    function automatic logic [W-1:0] sat_inc(input logic [W-1:0] v);
        return (v == '1) ? v : v + 1'b1;
    endfunction

    logic entered;
    logic strobe_rise;
    logic strobe_fall;
    logic setup_ok;
    logic hold_broken;
    logic hold_done;
    logic uv_trip;
    logic calm;
    logic powered_mode;
    logic reset_cause;
    logic wake_ev;
    logic [W-1:0] width_n;

    assign entered      = (mode_q != last_q);
    assign strobe_rise  = pins.mode_strobe && !strobe_q;
    assign strobe_fall  = !pins.mode_strobe && strobe_q;
    assign setup_ok     = (sel_cnt_q >= SETUP_N);
    assign hold_broken  = (pins.standby_select_n != hold_q.sel);
    assign hold_done    = (hold_cnt_q >= HOLD_N - 1'b1);
    assign width_n      = settings_q.reset_width_select ? RST_S_N : RST_L_N;
    assign uv_trip      = settings_q.uv_detect_en && (uv_cnt_q >= UV_N);
    assign calm         = pins.supply_ok && !pins.thermal_shutdown_state;
    assign powered_mode = mode_q inside {sbc_pkg::MODE_STANDBY, sbc_pkg::MODE_NORMAL,
                                         sbc_pkg::MODE_PIN_QUERY, sbc_pkg::MODE_PRE_SLEEP,
                                         sbc_pkg::MODE_SETUP_PROG};
    // own drive reads back low, so only an undriven low counts as outside reset
    assign reset_cause  = powered_mode &&
                          ((!reset_line_oe_q && !pins.reset_line_in) || uv_trip);
    assign wake_ev      = (pins.bus_wake && settings_q.bus_wake_en) ||
                          (pins.local_wake && settings_q.local_wake_en);

    // edge and stability history of the mode pins
    always_ff @(posedge clock) begin
        if (rst) begin
            strobe_q  <= 1'b0;
            sel_q     <= 1'b1;
            sel_cnt_q <= '0;
        end else begin
            strobe_q  <= pins.mode_strobe;
            sel_q     <= pins.standby_select_n;
            sel_cnt_q <= (pins.standby_select_n != sel_q) ? '0 : sat_inc(sel_cnt_q);
        end
    end

    // hold window and undervoltage filter counters
    always_ff @(posedge clock) begin
        if (rst) begin
            hold_cnt_q <= '0;
            uv_cnt_q   <= '0;
        end else begin
            hold_cnt_q <= hold_q.active ? sat_inc(hold_cnt_q) : '0;
            uv_cnt_q   <= (regulator_en_q && pins.vcc_under) ? sat_inc(uv_cnt_q) : '0;
        end
    end

    // mode timer restarts on every mode change
    always_ff @(posedge clock) begin
        if (rst) begin
            last_q <= sbc_pkg::MODE_OFF;
            tmr_q  <= '0;
        end else begin
            last_q <= mode_q;
            tmr_q  <= entered ? '0 : sat_inc(tmr_q);
        end
    end

    // mode sequencing
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q  <= sbc_pkg::MODE_RESET;
            hold_q  <= '0;
            route_q <= 1'b0;
        end else if (!pins.supply_ok) begin
            mode_q  <= sbc_pkg::MODE_OFF;
            hold_q  <= '0;
            route_q <= 1'b0;
        end else if (pins.thermal_shutdown_state) begin
            mode_q  <= sbc_pkg::MODE_THERMAL;
            hold_q  <= '0;
            route_q <= 1'b0;
        end else if (reset_cause) begin
            mode_q  <= sbc_pkg::MODE_RESET;
            hold_q  <= '0;
            route_q <= 1'b0;
        end else begin
            unique case (mode_q)
                sbc_pkg::MODE_OFF, sbc_pkg::MODE_THERMAL: begin
                    mode_q <= sbc_pkg::MODE_RESET;
                end
                sbc_pkg::MODE_RESET: begin
                    // mode pins are not looked at here
                    if (!reset_line_oe_q && pins.reset_line_in) begin
                        mode_q <= settings_q.settings_valid ? sbc_pkg::MODE_STANDBY
                                                            : sbc_pkg::MODE_SETUP_PROG;
                    end
                end
                sbc_pkg::MODE_SETUP_PROG: begin
                    if (settings_q.settings_valid) begin
                        mode_q <= sbc_pkg::MODE_RESET;
                    end
                end
                sbc_pkg::MODE_STANDBY: begin
                    if (hold_q.active) begin
                        if (hold_broken || hold_done) begin
                            hold_q.active <= 1'b0;
                            // any slip on the way lands in normal
                            mode_q <= (!hold_broken && hold_q.sel && hold_q.setup_ok)
                                      ? sbc_pkg::MODE_PIN_QUERY : sbc_pkg::MODE_NORMAL;
                        end
                    end else if (strobe_rise) begin
                        hold_q <= '{1'b1, pins.standby_select_n, setup_ok};
                    end
                end
                sbc_pkg::MODE_PIN_QUERY: begin
                    if (strobe_fall) begin
                        if (pins.standby_select_n) begin
                            hold_q <= '{1'b1, 1'b1, setup_ok};
                        end else begin
                            hold_q.active <= 1'b0;
                            mode_q        <= sbc_pkg::MODE_NORMAL;
                            route_q       <= 1'b1;
                        end
                    end else if (hold_q.active) begin
                        if (hold_q.sel) begin
                            if (hold_broken) begin
                                hold_q.active <= 1'b0;
                                mode_q        <= sbc_pkg::MODE_NORMAL;
                                route_q       <= 1'b1;
                            end else if (hold_done) begin
                                hold_q.active <= 1'b0;
                                mode_q        <= sbc_pkg::MODE_STANDBY;
                            end
                        end else if (hold_broken) begin
                            hold_q.active <= 1'b0;
                        end else if (hold_done) begin
                            hold_q.active <= 1'b0;
                            mode_q        <= sbc_pkg::MODE_NORMAL;
                        end
                    end else if (pins.mode_strobe && !pins.standby_select_n) begin
                        hold_q <= '{1'b1, 1'b0, setup_ok};
                    end
                end
                sbc_pkg::MODE_NORMAL: begin
                    if (route_q) begin
                        route_q <= 1'b0;
                        mode_q  <= sbc_pkg::MODE_STANDBY;
                    end else if (hold_q.active) begin
                        if (hold_broken || hold_done) begin
                            hold_q.active <= 1'b0;
                            // a broken hold follows the latched level, else setup decides
                            if (hold_broken ? hold_q.sel : (hold_q.sel ^ hold_q.setup_ok)) begin
                                mode_q <= sbc_pkg::MODE_STANDBY;
                            end else begin
                                mode_q <= sbc_pkg::MODE_PRE_SLEEP;
                            end
                        end
                    end else if (strobe_fall) begin
                        if (settings_q.sleep_entry_inhibit) begin
                            mode_q <= sbc_pkg::MODE_STANDBY;
                        end else begin
                            hold_q <= '{1'b1, pins.standby_select_n, setup_ok};
                        end
                    end
                end
                sbc_pkg::MODE_PRE_SLEEP: begin
                    if (pins.mode_strobe) begin
                        mode_q <= sbc_pkg::MODE_PIN_QUERY;
                    end else if (!entered && tmr_q >= PRE_N) begin
                        mode_q <= wake_q ? sbc_pkg::MODE_RESET : sbc_pkg::MODE_SLEEP;
                    end
                end
                sbc_pkg::MODE_SLEEP: begin
                    // with every wake source off only a power cycle or a thermal shutdown gets out
                    if (wake_q) begin
                        mode_q <= sbc_pkg::MODE_RESET;
                    end
                end
            endcase
        end
    end

    // wake flag, a new event wins over the clear on pre-sleep entry
    always_ff @(posedge clock) begin
        if (rst) begin
            wake_q <= 1'b0;
        end else if (wake_ev && mode_q inside {sbc_pkg::MODE_STANDBY, sbc_pkg::MODE_PIN_QUERY,
                                               sbc_pkg::MODE_PRE_SLEEP, sbc_pkg::MODE_SLEEP}) begin
            wake_q <= 1'b1;
        end else if (mode_q == sbc_pkg::MODE_NORMAL ||
                     (mode_q == sbc_pkg::MODE_PRE_SLEEP && entered)) begin
            wake_q <= 1'b0;
        end
    end

    // reset line drive, open drain: only ever pulls low
    always_ff @(posedge clock) begin
        reset_line_out_q <= 1'b0;
        if (rst) begin
            reset_line_oe_q <= 1'b1;
        end else if (mode_q inside {sbc_pkg::MODE_OFF, sbc_pkg::MODE_SLEEP,
                                    sbc_pkg::MODE_THERMAL}) begin
            reset_line_oe_q <= 1'b1;
        end else if (mode_q == sbc_pkg::MODE_RESET) begin
            if (entered) begin
                reset_line_oe_q <= 1'b1;
            end else if (tmr_q >= width_n - 1'b1 && !pins.vcc_under) begin
                reset_line_oe_q <= 1'b0;
            end
        end else if (reset_cause) begin
            reset_line_oe_q <= 1'b1;
        end else begin
            reset_line_oe_q <= 1'b0;
        end
    end

    // pin-side outputs follow the mode one cycle later
    always_ff @(posedge clock) begin
        if (rst) begin
            regulator_en_q <= 1'b1;
            lin_tx_en_q    <= 1'b0;
            lin_phy_en_q   <= 1'b1;
            rx_out_q       <= 1'b1;
        end else begin
            regulator_en_q <= powered_mode || mode_q == sbc_pkg::MODE_RESET;
            lin_tx_en_q    <= (mode_q == sbc_pkg::MODE_NORMAL);
            lin_phy_en_q   <= !(mode_q inside {sbc_pkg::MODE_OFF, sbc_pkg::MODE_SLEEP,
                                               sbc_pkg::MODE_THERMAL});
            unique case (mode_q)
                sbc_pkg::MODE_NORMAL:      rx_out_q <= pins.lin_rx;
                sbc_pkg::MODE_STANDBY,
                sbc_pkg::MODE_PIN_QUERY,
                sbc_pkg::MODE_PRE_SLEEP:   rx_out_q <= !wake_q;
                sbc_pkg::MODE_SETUP_PROG:  rx_out_q <= !pins.standby_select_n;
                default:                   rx_out_q <= 1'b1;
            endcase
        end
    end

    // settings register, the stored configuration
    always_ff @(posedge clock) begin
        if (rst) begin
            settings_q <= sbc_pkg::SETTINGS_RESET;
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0] &&
                     avs_address[3:2] == sbc_pkg::SETTINGS_OFF[3:2]) begin
            settings_q <= avs_writedata[5:0];
        end
    end

    // bus slave: one wait cycle, read data captured as the wait drops
    always_ff @(posedge clock) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= '0;
            if (avs_read && avs_address[3:2] == sbc_pkg::SETTINGS_OFF[3:2]) begin
                avs_readdata[5:0] <= settings_q;
            end else if (avs_read && avs_address[3:2] == sbc_pkg::STATUS_OFF[3:2]) begin
                avs_readdata[sbc_pkg::ST_MODE_LSB +: 4] <= mode_q;
                avs_readdata[sbc_pkg::ST_WAKE]          <= wake_q;
                avs_readdata[sbc_pkg::ST_REG_EN]        <= regulator_en_q;
                avs_readdata[sbc_pkg::ST_RST_DRV]       <= reset_line_oe_q;
                avs_readdata[sbc_pkg::ST_UV]            <= pins.vcc_under;
                avs_readdata[sbc_pkg::ST_HOLD]          <= hold_q.active;
            end
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    a_reg_sleep_off: assert property (@(posedge clock) disable iff (rst)
        mode_q inside {sbc_pkg::MODE_SLEEP, sbc_pkg::MODE_OFF} |=> !regulator_en_q)
        else $error("regulator on in sleep or off");

    a_uv_reset_entry: assert property (@(posedge clock) disable iff (rst)
        (calm && powered_mode && settings_q.uv_detect_en && uv_cnt_q >= UV_N)
        |=> mode_q == sbc_pkg::MODE_RESET ##1 reset_line_oe_q)
        else $error("filtered undervoltage did not reset");

    a_reset_to_standby: assert property (@(posedge clock) disable iff (rst)
        (calm && mode_q == sbc_pkg::MODE_RESET && !reset_line_oe_q &&
         pins.reset_line_in && settings_q.settings_valid) |=> mode_q == sbc_pkg::MODE_STANDBY)
        else $error("reset did not move to standby");

    a_ext_reset_hold: assert property (@(posedge clock) disable iff (rst)
        (mode_q == sbc_pkg::MODE_RESET && !pins.reset_line_in) |=> mode_q != sbc_pkg::MODE_STANDBY)
        else $error("standby entered while reset line low");

    a_reset_width: assert property (@(posedge clock) disable iff (rst)
        (mode_q == sbc_pkg::MODE_RESET && $past(mode_q) == sbc_pkg::MODE_RESET &&
         tmr_q < width_n - 1'b1) |=> reset_line_oe_q)
        else $error("reset line released before width");

    a_standby_tx_off: assert property (@(posedge clock) disable iff (rst)
        (mode_q == sbc_pkg::MODE_STANDBY) |=> !lin_tx_en_q && (rx_out_q == !$past(wake_q)))
        else $error("standby tx or wake report wrong");

    a_presleep_sleep: assert property (@(posedge clock) disable iff (rst)
        (calm && mode_q == sbc_pkg::MODE_PRE_SLEEP && !entered && tmr_q >= PRE_N &&
         !pins.mode_strobe && !wake_q && !reset_cause) |=> mode_q == sbc_pkg::MODE_SLEEP)
        else $error("pre-sleep timeout did not sleep");

    a_presleep_wake: assert property (@(posedge clock) disable iff (rst)
        (calm && mode_q == sbc_pkg::MODE_PRE_SLEEP && !entered && tmr_q >= PRE_N &&
         !pins.mode_strobe && wake_q) |=> mode_q == sbc_pkg::MODE_RESET)
        else $error("wake during pre-sleep did not reset");

    a_sleep_outputs: assert property (@(posedge clock) disable iff (rst)
        (mode_q == sbc_pkg::MODE_SLEEP) |=> reset_line_oe_q && !lin_phy_en_q && !regulator_en_q)
        else $error("sleep outputs wrong");

    a_ext_reset_entry: assert property (@(posedge clock) disable iff (rst)
        (calm && powered_mode && !reset_line_oe_q && !pins.reset_line_in)
        |=> mode_q == sbc_pkg::MODE_RESET)
        else $error("outside reset low ignored");

endmodule

`default_nettype wire

// >>> hw/sbc_pkg.sv
// shared constants and types of the operating-mode controller
package sbc_pkg;

    localparam int CLK_MHZ = 100;

    // least times: round up to whole clock cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETUP_NS       = 1000;
    localparam int HOLD_NS        = 1000;
    localparam int UV_FILTER_NS   = 10000;
    localparam int PRE_SLEEP_NS   = 1000000;
    localparam int RESET_SHORT_NS = 700000;
    localparam int RESET_LONG_NS  = 4000000;

    localparam int SETUP_CYC       = ns_to_cyc(SETUP_NS);
    localparam int HOLD_CYC        = ns_to_cyc(HOLD_NS);
    localparam int UV_FILTER_CYC   = ns_to_cyc(UV_FILTER_NS);
    localparam int PRE_SLEEP_CYC   = ns_to_cyc(PRE_SLEEP_NS);
    localparam int RESET_SHORT_CYC = ns_to_cyc(RESET_SHORT_NS);
    localparam int RESET_LONG_CYC  = ns_to_cyc(RESET_LONG_NS);

    localparam int TMR_W = 20;

    // register map, byte addresses
    localparam logic [3:0] SETTINGS_OFF = 4'h0;
    localparam logic [3:0] STATUS_OFF   = 4'h4;

    // field positions of the status word
    localparam int ST_MODE_LSB = 0;
    localparam int ST_WAKE     = 4;
    localparam int ST_REG_EN   = 5;
    localparam int ST_RST_DRV  = 6;
    localparam int ST_UV       = 7;
    localparam int ST_HOLD     = 8;

    typedef enum logic [3:0] {
        MODE_OFF, MODE_RESET, MODE_STANDBY, MODE_NORMAL, MODE_PIN_QUERY,
        MODE_PRE_SLEEP, MODE_SLEEP, MODE_SETUP_PROG, MODE_THERMAL
    } sbc_mode_type;

    // bit 0 lowest
    typedef struct packed {
        logic local_wake_en;
        logic bus_wake_en;
        logic settings_valid;
        logic uv_detect_en;
        logic sleep_entry_inhibit;
        logic reset_width_select;
    } sbc_settings_type;

    localparam sbc_settings_type SETTINGS_RESET = 6'h3c;

    typedef struct packed {
        logic supply_ok;
        logic thermal_shutdown_state;
        logic vcc_under;
        logic bus_wake;
        logic local_wake;
        logic lin_rx;
        logic reset_line_in;
        logic standby_select_n;
        logic mode_strobe;
    } sbc_pins_type;

    // pending hold window: level latched at the strobe edge, or at select low while strobe high in pin-query
    typedef struct packed {
        logic active;
        logic sel;
        logic setup_ok;
    } sbc_hold_type;

endpackage

// >>> tb/sbc_host_model.sv
// host microcontroller model driving the mode pins and the reset wire
`timescale 1ns/1ns
`default_nettype none
module sbc_host_model #(
    parameter int SETUP = 4,
    parameter int HOLD  = 4
) (
    // clock
    input  wire logic clock,
    // mode pins and outside reset pull
    output var  logic sel_n,
    output var  logic strobe,
    output var  logic pull_low
);
    // strobe low at rest keeps the device in standby
    initial begin
        sel_n = 1'b1;
        strobe = 1'b0;
        pull_low = 1'b0;
    end
    // select settles a margin beyond setup, then is held beyond hold
    task automatic step(input logic s, input logic e);
        @(posedge clock);
        sel_n <= s;
        repeat (SETUP + 2) @(posedge clock);
        strobe <= e;
        repeat (HOLD + 4) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// >>> tb/sbc_mode_ctrl_tb.sv
// self-checking bench of the operating-mode controller
`timescale 1ns/1ns
`default_nettype none
module sbc_mode_ctrl_tb;
    logic        clock = 1'b0, rst = 1'b1, wake = 1'b0;
    logic        sup = 1'b1, therm = 1'b0, uv = 1'b0, bwake = 1'b0, lin = 1'b1;
    logic        rd_en = 1'b0, wr_en = 1'b0;
    logic [3:0]  addr = 4'h0, be = 4'hf;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        reg_en, oe, odat, rx, tx, phy, wreq;
    logic        sel_n, strobe, pull_low;
    int          err_total = 0, total_checks = 0;
    // table of host steps: select level, strobe level, mode reached
    logic        sel_t [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic        str_t [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [3:0]  md_t [5]  = '{4'h3, 4'h2, 4'h4, 4'h3, 4'h5};
    // open-drain reset wire with pull-up
    wire         rline = !(oe || pull_low);
    wire sbc_pkg::sbc_pins_type pins = {sup, therm, uv, bwake, wake, lin, rline, sel_n, strobe};
    sbc_host_model #(.SETUP(4), .HOLD(4)) host (.clock(clock), .sel_n(sel_n), .strobe(strobe),
        .pull_low(pull_low));
    sbc_mode_ctrl #(.SETUP_CYC(4), .HOLD_CYC(4), .UV_FILTER_CYC(4), .PRE_SLEEP_CYC(50),
        .RESET_SHORT_CYC(20), .RESET_LONG_CYC(40)) dut (.clock(clock), .rst(rst), .pins(pins),
        .regulator_en_q(reg_en), .reset_line_out_q(odat), .reset_line_oe_q(oe), .rx_out_q(rx),
        .lin_tx_en_q(tx), .lin_phy_en_q(phy), .avs_address(addr), .avs_read(rd_en),
        .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wreq));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        rd_en <= !w;
        wr_en <= w;
        addr <= a;
        wdata <= d;
        do @(posedge clock); while (wreq !== 1'b0);
        rd = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    task automatic wait_mode(input logic [3:0] m);
        int n;
        n = 0;
        do begin
            bus(1'b0, 4'h4, 32'h0);
            n++;
        end while (rd[3:0] !== m && n < 300);
        chk("mode", {28'h0, rd[3:0]}, {28'h0, m});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, 4'h0, 32'h0);
        chk("settings", rd, 32'h3c);
        bus(1'b0, 4'h8, 32'h0);
        chk("unmapped", rd, 32'h0);
        wait_mode(4'h2);
        chk("regulator", {31'h0, reg_en}, 32'h1);
        bus(1'b1, 4'h0, 32'h3d);
        bus(1'b1, 4'hc, 32'h0);
        be <= 4'h0;
        bus(1'b1, 4'h0, 32'h0);
        be <= 4'hf;
        bus(1'b0, 4'h0, 32'h0);
        chk("settings", rd, 32'h3d);
        for (int i = 0; i < 5; i++) begin
            host.step(sel_t[i], str_t[i]);
            wait_mode(md_t[i]);
        end
        wait_mode(4'h6);
        chk("sleep regulator", {31'h0, reg_en}, 32'h0);
        chk("sleep reset", {31'h0, oe}, 32'h1);
        chk("sleep phy", {31'h0, phy}, 32'h0);
        chk("reset data", {31'h0, odat}, 32'h0);
        wake <= 1'b1;
        wait_mode(4'h2);
        chk("wake rx", {31'h0, rx}, 32'h0);
        chk("standby tx", {31'h0, tx}, 32'h0);
        wake <= 1'b0;
        host.step(1'b0, 1'b1);
        wait_mode(4'h3);
        lin <= 1'b0;
        repeat (2) @(posedge clock);
        chk("normal rx", {31'h0, rx}, 32'h0);
        chk("normal tx", {31'h0, tx}, 32'h1);
        lin <= 1'b1;
        host.step(1'b1, 1'b0);
        wait_mode(4'h5);
        bwake <= 1'b1;
        repeat (3) @(posedge clock);
        chk("presleep rx", {31'h0, rx}, 32'h0);
        wait_mode(4'h1);
        bwake <= 1'b0;
        wait_mode(4'h2);
        host.step(1'b0, 1'b1);
        wait_mode(4'h3);
        host.step(1'b1, 1'b0);
        wait_mode(4'h5);
        host.step(1'b1, 1'b1);
        wait_mode(4'h4);
        host.step(1'b1, 1'b0);
        wait_mode(4'h2);
        bus(1'b1, 4'h0, 32'h3f);
        host.step(1'b0, 1'b1);
        wait_mode(4'h3);
        host.step(1'b1, 1'b0);
        wait_mode(4'h2);
        therm <= 1'b1;
        wait_mode(4'h8);
        therm <= 1'b0;
        wait_mode(4'h2);
        sup <= 1'b0;
        wait_mode(4'h0);
        chk("off regulator", {31'h0, reg_en}, 32'h0);
        sup <= 1'b1;
        wait_mode(4'h2);
        uv <= 1'b1;
        wait_mode(4'h1);
        uv <= 1'b0;
        wait_mode(4'h2);
        host.pull_low <= 1'b1;
        wait_mode(4'h1);
        repeat (60) @(posedge clock);
        bus(1'b1, 4'h0, 32'h37);
        wait_mode(4'h1);
        host.pull_low <= 1'b0;
        wait_mode(4'h7);
        chk("setup rx", {31'h0, rx}, 32'h0);
        bus(1'b1, 4'h0, 32'h3f);
        wait_mode(4'h2);
        wrap_up();
    end
endmodule
`default_nettype wire
